// >>> bench/sspo_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module sspo_plc_model
#(
  parameter HOLD = 12
)
(
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  input  wire logic       gate_i,
  input  wire logic [1:0] cmd_i,
  input  wire logic       phase_a_i,
  output wire logic       fwd_o,
  output wire logic       rev_o,
  output var  logic [7:0] a_cnt_o
);
  int         hold = 0;
  logic [1:0] pend = 2'h0;
  logic [1:0] act = 2'h0;
  assign fwd_o = hold > 0 && act[0];
  assign rev_o = hold > 0 && act[1];
  initial a_cnt_o = 8'h0;
  always @(posedge phase_a_i) a_cnt_o++;
  always @(posedge clk_i)
  begin
    if (cmd_i != 2'h0)
      pend = cmd_i;
    #1;
    if (hold > 0)
      hold--;
    else if (pend != 2'h0 && (ready_i || !gate_i))
    begin
      act = pend;
      pend = 2'h0;
      hold = HOLD;
    end
  end
endmodule
`default_nettype wire

// >>> bench/sspo_servo_io_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sspo_servo_io_chk
#(
  parameter START_CYC = 5
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic main_circuit_ok_i,
  input wire logic enc_step_i,
  input wire logic start_fwd_o,
  input wire logic start_rev_o,
  input wire logic movement_complete_out_o,
  input wire logic phase_a_pos_o,
  input wire logic phase_b_pos_o,
  input wire logic zero_point_oc_out_o,
  input wire logic zero_phase_pos_o
);
  localparam int HI = START_CYC + 3;
  wire logic       st = start_fwd_o | start_rev_o;
  wire logic       z  = zero_point_oc_out_o;
  wire logic       pc = movement_complete_out_o;
  wire logic [1:0] ab = {phase_a_pos_o, phase_b_pos_o};
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  zero_pair_a: assert property (zero_phase_pos_o != z)
    else $error("zero pair");
  step_moves_a: assert property (
    enc_step_i |=> $countones(ab ^ $past(ab)) == 1) else $error("step");
  idle_hold_a: assert property (
    !enc_step_i |=> $stable(ab)) else $error("drift");
  zero_width_a: assert property ($fell(z) |-> !z [*8])
    else $error("zero short");
  done_main_a: assert property (pc |-> $past(main_circuit_ok_i))
    else $error("idle");
  start_busy_a: assert property (
    st |-> !pc && !(start_fwd_o && start_rev_o)) else $error("busy");
  start_one_a: assert property (st |=> !st)
    else $error("double");
  start_lat_a: assert property (
    $fell(pc) && main_circuit_ok_i |-> ##[1:HI] st) else $error("late");
  cover property (start_fwd_o);
  cover property (start_rev_o);
  cover property ($fell(z));
endmodule
bind sspo_servo_io sspo_servo_io_chk #(.START_CYC(START_CYC)) u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .main_circuit_ok_i(main_circuit_ok_i), .enc_step_i(enc_step_i),
  .start_fwd_o(start_fwd_o), .start_rev_o(start_rev_o),
  .movement_complete_out_o(movement_complete_out_o),
  .phase_a_pos_o(phase_a_pos_o), .phase_b_pos_o(phase_b_pos_o),
  .zero_point_oc_out_o(zero_point_oc_out_o),
  .zero_phase_pos_o(zero_phase_pos_o)
);
`default_nettype wire

// >>> bench/sspo_servo_io_test.sv
`timescale 1ns/1ps
`default_nettype none
module sspo_servo_io_test;
  localparam int Z = 10;
  logic        clk = 1'h0, rst_n = 1'h0, swap = 1'h0, ser = 1'h0;
  logic        stp_q = 1'h0, ccw = 1'h0, mok = 1'h0, done = 1'h0;
  logic        gate = 1'h0, tx = 1'h0;
  logic [1:0]  cmd = 2'h0;
  logic [15:0] nf = 16'h0, nr = 16'h0;
  wire logic   fwd, rev, sf, sr, pc, rdy, a, b, zoc, zp, zn, r4, r2;
  wire logic   an, bn, tp, tn, t2;
  wire logic [7:0] ac;
  int          num_errors = 0, checks_done = 0;
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    nf <= nf + {15'h0, sf === 1'h1};
    nr <= nr + {15'h0, sr === 1'h1};
  end
  sspo_servo_io #(.FILT_CYC(4), .ZERO_CYC(Z), .START_CYC(5)) dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .pulses_per_rev_i(16'h2),
    .phase_swap_i(swap), .serial_sel_i(ser), .enc_step_i(stp_q),
    .enc_dir_ccw_i(ccw), .main_circuit_ok_i(mok), .move_done_i(done),
    .forward_start_in_i(fwd), .reverse_start_in_i(rev), .start_fwd_o(sf),
    .start_rev_o(sr), .movement_complete_out_o(pc), .ready_o(rdy),
    .phase_a_pos_o(a), .phase_a_neg_o(an), .phase_b_pos_o(b),
    .phase_b_neg_o(bn), .zero_point_oc_out_o(zoc), .zero_phase_pos_o(zp),
    .zero_phase_neg_o(zn), .serial_tx_i(tx), .serial_tx_pos_o(tp),
    .serial_tx_neg_o(tn), .rs422_en_o(r4), .rs232_en_o(r2), .rs232_tx_o(t2)
  );
  sspo_plc_model plc (
    .clk_i(clk), .ready_i(rdy), .gate_i(gate), .cmd_i(cmd),
    .phase_a_i(a), .fwd_o(fwd), .rev_o(rev), .a_cnt_o(ac)
  );
  //////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk_n(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk(input logic g, input logic e);
    chk_n({15'h0, g}, {15'h0, e});
  endtask
  task go(input logic [1:0] c, input logic g);
    logic [15:0] k;
    k = nf + nr;
    cmd = c;
    gate = g;
    cyc(1);
    cmd = 2'h0;
    for (int i = 0; i < 30 && nf + nr == k; i++)
      cyc(1);
  endtask
  task fin;
    done = 1'h1;
    cyc(1);
    done = 1'h0;
    cyc(3);
    chk(pc, 1'h1);
    chk(rdy, 1'h1);
  endtask
  task t_main;
    chk(rdy, 1'h0);
    cmd = 2'h1;
    cyc(1);
    cmd = 2'h0;
    cyc(9);
    mok = 1'h1;
    cyc(30);
    chk_n(nf, 16'h0);
    chk(pc, 1'h1);
    $display("%0t main end", $time);
  endtask
  task t_starts;
    go(2'h1, 1'h1);
    chk_n(nf, 16'h1);
    chk(pc, 1'h0);
    go(2'h2, 1'h0);
    chk_n(nr, 16'h0);
    fin;
    go(2'h2, 1'h1);
    chk_n(nr, 16'h1);
    fin;
    $display("%0t starts end", $time);
  endtask
  task stp(input logic d);
    stp_q = 1'h1;
    ccw = d;
    cyc(1);
    stp_q = 1'h0;
    cyc(1);
  endtask
  task t_enc;
    logic [1:0] g [4];
    int         k;
    g = '{2'h0, 2'h2, 2'h3, 2'h1};
    k = 0;
    for (int i = 1; i <= 8; i++)
    begin
      chk(zoc, 1'h1);
      stp(1'h1);
      chk_n({14'h0, a, b}, {14'h0, g[i % 4]});
      chk_n({14'h0, an, bn}, {14'h0, ~g[i % 4]});
    end
    chk(zp, 1'h1);
    chk(zn, 1'h0);
    while (zoc === 1'h0 && k < 40)
    begin
      k++;
      cyc(1);
    end
    chk(k >= Z - 3 && k <= Z + 1, 1'h1);
    chk_n({8'h0, ac}, 16'h2);
    stp(1'h0);
    chk_n({14'h0, a, b}, 16'h1);
    stp(1'h1);
    swap = 1'h1;
    cyc(2);
    stp(1'h1);
    chk_n({14'h0, a, b}, 16'h1);
    stp(1'h0);
    swap = 1'h0;
    $display("%0t enc end", $time);
  endtask
  task t_ser;
    for (int s = 0; s < 4; s++)
    begin
      ser = s[0];
      tx = s[1];
      cyc(2);
      chk(r2, s[0]);
      chk(r4, !s[0]);
      chk(tp, s[0] ? 1'h1 : s[1]);
      chk(tn, s[0] ? 1'h0 : !s[1]);
      chk(t2, s[0] ? s[1] : 1'h1);
    end
    $display("%0t ser end", $time);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    rst_n = 1'h1;
    t_main;
    t_starts;
    t_enc;
    t_ser;
    finish_test;
  end
  initial
  begin
    cyc(4000);
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire

// >>> rtl/sspo_regs.vh
`ifndef SSPO_REGS_VH
`define SSPO_REGS_VH

// clock rate and derived timing
`define SSPO_CLK_HZ          20000000
`define SSPO_ZERO_MIN_US     400
`define SSPO_ZERO_MIN_CYC    ((`SSPO_ZERO_MIN_US * 20) )
`define SSPO_START_DLY_MS    3
`define SSPO_START_DLY_CYC   ((`SSPO_START_DLY_MS * (`SSPO_CLK_HZ / 1000)))
`define SSPO_SIG_DLY_MS      10
`define SSPO_FILT_US         1000
`define SSPO_FILT_CYC        ((`SSPO_FILT_US * (`SSPO_CLK_HZ / 1000000)))
// default pulses per revolution and parameter-58 reset value
`define SSPO_PPR_DEFAULT     16'd4000
`define SSPO_SER_RS422       1'b0
`define SSPO_SER_RS232       1'b1

`endif

// >>> rtl/sspo_servo_io.v
`timescale 1ns/1ps
`default_nettype none
`include "sspo_regs.vh"

module sspo_servo_io
#(
  parameter PPR_W     = 16,
  parameter FILT_CYC  = `SSPO_FILT_CYC,
  parameter ZERO_CYC  = `SSPO_ZERO_MIN_CYC,
  parameter START_CYC = `SSPO_START_DLY_CYC
)
(
  // clock and reset
  input  wire             core_clk_i,
  input  wire             reset_n_i,
  // configuration
  input  wire [PPR_W-1:0] pulses_per_rev_i,
  input  wire             phase_swap_i,
  input  wire             serial_sel_i,
  // motor position feedback, one step per output edge
  input  wire             enc_step_i,
  input  wire             enc_dir_ccw_i,
  // status from drive
  input  wire             main_circuit_ok_i,
  input  wire             move_done_i,
  // start inputs
  input  wire             forward_start_in_i,
  input  wire             reverse_start_in_i,
  // start commands to motion core, movement complete and ready status
  output reg              start_fwd_o,
  output reg              start_rev_o,
  output reg              movement_complete_out_o,
  output reg              ready_o,
  // encoder emulation
  output reg              phase_a_pos_o,
  output reg              phase_a_neg_o,
  output reg              phase_b_pos_o,
  output reg              phase_b_neg_o,
  output reg              zero_point_oc_out_o,
  output reg              zero_phase_pos_o,
  output reg              zero_phase_neg_o,
  // serial port enables and tx
  input  wire             serial_tx_i,
  output reg              serial_tx_pos_o,
  output reg              serial_tx_neg_o,
  output reg              rs422_en_o,
  output reg              rs232_en_o,
  output reg              rs232_tx_o
);

  ////////////////////////////////////////////////////////////////////////////
  // start path

  wire fwd_lvl;
  wire fwd_rise;
  wire rev_lvl;
  wire rev_rise;

  sspo_start_filter #(.FILT_CYC(FILT_CYC)) u_fwd
  (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .raw_i      (forward_start_in_i),
    .level_o    (fwd_lvl),
    .rise_o     (fwd_rise)
  );

  sspo_start_filter #(.FILT_CYC(FILT_CYC)) u_rev
  (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .raw_i      (reverse_start_in_i),
    .level_o    (rev_lvl),
    .rise_o     (rev_rise)
  );

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_MOVE = 3'b100;

  reg  [2:0]  state;
  reg  [16:0] dly;
  reg         pend_rev;

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state                   <= ST_IDLE;
      dly                     <= 17'h00000;
      pend_rev                <= 1'b0;
      start_fwd_o             <= 1'b0;
      start_rev_o             <= 1'b0;
      movement_complete_out_o <= 1'b0;
      ready_o                 <= 1'b0;
    end
    else
    begin
      start_fwd_o <= 1'b0;
      start_rev_o <= 1'b0;
      ready_o     <= main_circuit_ok_i && (state == ST_IDLE);
      case (state)
        ST_IDLE:
        begin
          movement_complete_out_o <= main_circuit_ok_i;
          // edges before the main circuit is up are dropped
          if (main_circuit_ok_i && (fwd_rise || rev_rise))
          begin
            pend_rev <= rev_rise && !fwd_rise;
            dly      <= 17'h00000;
            state    <= ST_WAIT;
            movement_complete_out_o <= 1'b0;
          end
        end
        ST_WAIT:
        begin
          // fixed internal delay from the filtered edge, at the 3 ms limit
          if (dly == START_CYC[16:0] - 17'h00001)
          begin
            start_fwd_o <= !pend_rev;
            start_rev_o <= pend_rev;
            state       <= ST_MOVE;
          end
          else
            dly <= dly + 17'h00001;
        end
        ST_MOVE:
        begin
          // edges seen here are discarded
          if (move_done_i)
          begin
            movement_complete_out_o <= 1'b1;
            state                   <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // encoder emulation

  localparam [PPR_W+1:0] POS_ONE = {{(PPR_W+1){1'b0}}, 1'b1};

  reg [1:0]       quad;
  reg [PPR_W+1:0] pos;
  reg [15:0]      zhold;

  wire [PPR_W+1:0] edges_per_rev = {pulses_per_rev_i, 2'b00};
  wire             ccw_eff       = enc_dir_ccw_i ^ phase_swap_i;
  wire             at_last       = (pos == edges_per_rev - POS_ONE);
  wire             zero_hit;
  wire [1:0]       quad_nxt;

  // gray sequence: A leads B when ccw_eff is set, B leads A when it is clear
  assign quad_nxt = !enc_step_i ? quad
                  : ccw_eff     ? {~quad[0], quad[1]}
                                : {quad[0], ~quad[1]};

  assign zero_hit = enc_step_i &&
                    ((enc_dir_ccw_i && at_last) ||
                     (!enc_dir_ccw_i && pos == {(PPR_W+2){1'b0}}));

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      quad                <= 2'b00;
      pos                 <= {(PPR_W+2){1'b0}};
      zhold               <= 16'h0000;
      phase_a_pos_o       <= 1'b0;
      phase_a_neg_o       <= 1'b1;
      phase_b_pos_o       <= 1'b0;
      phase_b_neg_o       <= 1'b1;
      zero_point_oc_out_o <= 1'b1;
      zero_phase_pos_o    <= 1'b0;
      zero_phase_neg_o    <= 1'b1;
    end
    else
    begin
      quad <= quad_nxt;
      if (enc_step_i)
      begin
        if (enc_dir_ccw_i)
          pos <= at_last ? {(PPR_W+2){1'b0}} : pos + POS_ONE;
        else
          pos <= (pos == {(PPR_W+2){1'b0}}) ? edges_per_rev - POS_ONE
                                            : pos - POS_ONE;
      end
      if (zero_hit)
        zhold <= ZERO_CYC[15:0];
      else if (zhold != 16'h0000)
        zhold <= zhold - 16'h0001;
      phase_a_pos_o       <= quad_nxt[1];
      phase_a_neg_o       <= ~quad_nxt[1];
      phase_b_pos_o       <= quad_nxt[0];
      phase_b_neg_o       <= ~quad_nxt[0];
      zero_point_oc_out_o <= !(zero_hit || zhold != 16'h0000);
      zero_phase_pos_o    <= zero_hit || zhold != 16'h0000;
      zero_phase_neg_o    <= !(zero_hit || zhold != 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port select

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rs422_en_o      <= 1'b0;
      rs232_en_o      <= 1'b0;
      serial_tx_pos_o <= 1'b1;
      serial_tx_neg_o <= 1'b0;
      rs232_tx_o      <= 1'b1;
    end
    else
    begin
      rs422_en_o      <= (serial_sel_i == `SSPO_SER_RS422);
      rs232_en_o      <= (serial_sel_i == `SSPO_SER_RS232);
      serial_tx_pos_o <= (serial_sel_i == `SSPO_SER_RS422) ? serial_tx_i
                                                           : 1'b1;
      serial_tx_neg_o <= (serial_sel_i == `SSPO_SER_RS422) ? ~serial_tx_i
                                                           : 1'b0;
      rs232_tx_o      <= (serial_sel_i == `SSPO_SER_RS232) ? serial_tx_i
                                                           : 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sspo_start_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "sspo_regs.vh"

module sspo_start_filter
#(
  parameter FILT_CYC = `SSPO_FILT_CYC
)
(
  // clock and reset
  input  wire core_clk_i,
  input  wire reset_n_i,
  // raw input and outputs
  input  wire raw_i,
  output reg  level_o,
  output reg  rise_o
);

  reg        sync_a;
  reg        sync_b;
  reg [15:0] cnt;

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      cnt     <= 16'h0000;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
    end
    else
    begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      rise_o <= 1'b0;
      if (sync_b == level_o)
        cnt <= 16'h0000;
      else if (cnt == FILT_CYC[15:0] - 16'h0001)
      begin
        cnt     <= 16'h0000;
        level_o <= sync_b;
        rise_o  <= sync_b;
      end
      else
        cnt <= cnt + 16'h0001;
    end
  end

endmodule
`default_nettype wire
